// File: pkg/sse_map.vh
`ifndef SSE_MAP_VH
`define SSE_MAP_VH

// register byte addresses
`define SSE_ENABLE_OFS        16'hf748
`define SSE_DISABLE_OFS       16'hf74c

// field positions inside the enable and disable registers
`define SSE_MAIN_PCM_TX_BIT   0
`define SSE_REAR_PAIR_TX_BIT  1
`define SSE_CENTER_TX_BIT     2
`define SSE_LOW_FREQ_TX_BIT   3
`define SSE_AUDIO_RX_BIT      4
`define SSE_MODEM_TX_BIT      6
`define SSE_MODEM_RX_BIT      7
`define SSE_GP_OUTPUT_BIT     8
`define SSE_GP_INPUT_BIT      9
`define SSE_PENDING_BIT       16

// stream field width and the bits that really exist (bit 5 reserved)
`define SSE_STREAM_W          10
`define SSE_STREAM_MASK       10'h3df

// reset value of every stream enable
`define SSE_STREAM_RESET      10'h000

// rising link clock edges a write waits before it is applied
`define SSE_APPLY_EDGES       3

`endif

// File: rtl/sse_rise_det.v
`timescale 1ns/1ps
`default_nettype none

module sse_rise_det (
  // clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // synchronised level and its rising edge pulse
  input  wire level_i,
  output wire rise_o
);

  reg last;
  reg rise;

  // one-cycle pulse the cycle after the level goes high
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      last <= 1'b0;
      rise <= 1'b0;
    end
    else
    begin
      last <= level_i;
      rise <= level_i & ~last;
    end
  end

  assign rise_o = rise;

endmodule

`default_nettype wire

// File: rtl/sse_slot_gate.v
// Overview of operation
// - writing 1 to enable bit 4 sets audio receive; reads show it
// - writing 1 to enable bit 3 sets low-frequency output; reads show it
// - writing 1 to enable bit 2 sets center output; reads show it
// - writing 1 to enable bit 1 sets surround output; reads show it
// - writing 1 to enable bit 0 sets main pcm output; reads show it
// - disable bits 9 and 8 clear gp input and gp output enables
// - disable bits 7 and 6 clear modem input and output enables
// - disable bit 4 clears audio input enable; zero does nothing
// - disable bit 3 clears low-frequency output enable
// - disable bit 2 clears center output enable
// - disable bit 1 clears surround output enable
// - disable bit 0 clears main pcm output enable
// - writes take effect only after several link clock cycles
// - enable bit 16 reads 1 while a write is still being applied
// - enable bits 9 to 6 set gp and modem enables; reads show them
`timescale 1ns/1ps
`default_nettype none
`include "sse_map.vh"

module sse_slot_gate #(
  parameter ADR_W       = 16,
  parameter APPLY_EDGES = `SSE_APPLY_EDGES
) (
  // system clock and reset
  input  wire             clk_i,
  input  wire             rst_i,
  // wishbone classic slave
  input  wire             cyc_i,
  input  wire             stb_i,
  input  wire             we_i,
  input  wire [ADR_W-1:0] adr_i,
  input  wire [3:0]       sel_i,
  input  wire [31:0]      dat_i,
  output wire [31:0]      dat_o,
  output wire             ack_o,
  // link bit clock from the codec
  input  wire             bit_clk_i,
  // stream enables towards the slot logic
  output wire             gp_input_stream_bit_o,
  output wire             gp_output_stream_bit_o,
  output wire             modem_rx_stream_bit_o,
  output wire             modem_tx_stream_bit_o,
  output wire             audio_rx_stream_bit_o,
  output wire             low_freq_tx_stream_bit_o,
  output wire             center_tx_stream_bit_o,
  output wire             rear_pair_tx_stream_bit_o,
  output wire             main_pcm_tx_stream_bit_o,
  // write still being applied
  output wire             write_pending_flag_o
);

  localparam SW = `SSE_STREAM_W;
  localparam [3:0] EDGE_LAST = APPLY_EDGES - 1;

  ////////////////////////////////////////////////////////////////////////
  // link clock edge detection

  wire bit_clk_sync;
  wire bit_clk_rise;

  sse_sync2 #(
    .WIDTH   (1)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (bit_clk_i),
    .sync_o  (bit_clk_sync)
  );

  sse_rise_det u_rise (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .level_i (bit_clk_sync),
    .rise_o  (bit_clk_rise)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  reg  [31:0]   rd_data;
  reg           ack;
  reg  [SW-1:0] stream_en;
  reg  [SW-1:0] set_mask;
  reg  [SW-1:0] clr_mask;
  reg           pending;
  reg  [3:0]    edge_cnt;

  wire          req     = cyc_i & stb_i & ~ack;
  wire          hit_en  = adr_i[15:2] == `SSE_ENABLE_OFS >> 2;
  wire          hit_dis = adr_i[15:2] == `SSE_DISABLE_OFS >> 2;
  // byte lane 0 carries bits 7:0, lane 1 bits 9:8
  wire [SW-1:0] lane_mask = {{2{sel_i[1]}}, {8{sel_i[0]}}};
  wire [SW-1:0] wr_bits   = dat_i[SW-1:0] & lane_mask & `SSE_STREAM_MASK;
  // a write while one is still in flight is dropped, not merged
  wire          wr_take   = req & we_i & ~pending;

  // enable readback: reserved bits stay zero
  reg  [31:0] next_rd_data;
  always @*
  begin
    next_rd_data = 32'h0000_0000;
    if (hit_en)
    begin
      next_rd_data[SW-1:0] = stream_en & `SSE_STREAM_MASK;
      next_rd_data[`SSE_PENDING_BIT] = pending;
    end
  end

  // single-wait-state ack; unmapped addresses ack with zero data
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack     <= 1'b0;
      rd_data <= 32'h0000_0000;
    end
    else
    begin
      ack     <= req;
      rd_data <= (req & ~we_i) ? next_rd_data : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write capture and deferred apply on link clock edges

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stream_en <= `SSE_STREAM_RESET;
      set_mask  <= {SW{1'b0}};
      clr_mask  <= {SW{1'b0}};
      pending   <= 1'b0;
      edge_cnt  <= 4'h0;
    end
    else if (wr_take & (hit_en | hit_dis))
    begin
      // ones set (enable) or clear (disable); zeros carry no effect
      set_mask <= hit_en  ? wr_bits : {SW{1'b0}};
      clr_mask <= hit_dis ? wr_bits : {SW{1'b0}};
      pending  <= 1'b1;
      edge_cnt <= 4'h0;
    end
    else if (pending & bit_clk_rise)
    begin
      // a stopped link clock leaves the write pending indefinitely
      if (edge_cnt == EDGE_LAST)
      begin
        // set bits 9..6 and 4..0
        // clear bits 9..6 and 4..0
        stream_en <= (stream_en | set_mask) & ~clr_mask;
        pending   <= 1'b0;
      end
      else
      begin
        edge_cnt <= edge_cnt + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign dat_o                     = rd_data;
  assign ack_o                     = ack;
  assign write_pending_flag_o      = pending;
  assign gp_input_stream_bit_o     = stream_en[`SSE_GP_INPUT_BIT];
  assign gp_output_stream_bit_o    = stream_en[`SSE_GP_OUTPUT_BIT];
  assign modem_rx_stream_bit_o     = stream_en[`SSE_MODEM_RX_BIT];
  assign modem_tx_stream_bit_o     = stream_en[`SSE_MODEM_TX_BIT];
  assign audio_rx_stream_bit_o     = stream_en[`SSE_AUDIO_RX_BIT];
  assign low_freq_tx_stream_bit_o  = stream_en[`SSE_LOW_FREQ_TX_BIT];
  assign center_tx_stream_bit_o    = stream_en[`SSE_CENTER_TX_BIT];
  assign rear_pair_tx_stream_bit_o = stream_en[`SSE_REAR_PAIR_TX_BIT];
  assign main_pcm_tx_stream_bit_o  = stream_en[`SSE_MAIN_PCM_TX_BIT];

endmodule

`default_nettype wire

// File: rtl/sse_sync2.v
`timescale 1ns/1ps
`default_nettype none

module sse_sync2 #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             clk_i,
  input  wire             rst_i,
  // asynchronous input and its synchronised copy
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] stable;

  // two flops; only the second one is visible outside
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta   <= {WIDTH{1'b0}};
      stable <= {WIDTH{1'b0}};
    end
    else
    begin
      meta   <= async_i;
      stable <= meta;
    end
  end

  assign sync_o = stable;

endmodule

`default_nettype wire

// File: sim/sse_codec_model.sv
`timescale 1ns/1ps
`default_nettype none
module sse_codec_model (
  // pacing chosen by the bench
  input  wire logic slow_i,
  // link bit clock
  output var  logic bit_clk_o
);
  // runs free like a real codec; odd start keeps it off the system phase
  initial
  begin
    bit_clk_o = 1'b0;
    #13;
    forever #(slow_i ? 80 : 40) bit_clk_o = ~bit_clk_o;
  end
endmodule
`default_nettype wire

// File: sim/sse_slot_gate_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sse_slot_gate_asserts (
  // bus side
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [15:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // stream side
  input wire logic        write_pending_flag_o,
  input wire logic        audio_rx_stream_bit_o,
  input wire logic        main_pcm_tx_stream_bit_o,
  input wire logic        gp_input_stream_bit_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a request taken, then an accepted write to a stream register
  sequence s_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_wen;
    s_take ##0 we_i && !write_pending_flag_o &&
      (adr_i == 16'hf748 || adr_i == 16'hf74c);
  endsequence
  chk_ack_one: assert property (s_take |=> ack_o)
    else $error("request without ack");
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_pend_set: assert property (s_wen |=> write_pending_flag_o)
    else $error("pending not set by write");
  chk_apply_wait: assert property ($rose(write_pending_flag_o) |->
    write_pending_flag_o [*8]) else $error("applied too soon");
  chk_apply_bound: assert property ($rose(write_pending_flag_o) |->
    ##[1:80] !write_pending_flag_o) else $error("apply never ends");
  // enables may move only on the edge where pending clears
  chk_hold_state: assert property (!$fell(write_pending_flag_o) |->
    $stable(audio_rx_stream_bit_o) && $stable(main_pcm_tx_stream_bit_o))
    else $error("enable moved without apply");
  chk_rsvd_zero: assert property (ack_o |-> dat_o[31:17] == 15'h0 &&
    dat_o[15:10] == 6'h0 && !dat_o[5]) else $error("reserved bit set");
  chk_rd_state: assert property (ack_o && $past(!we_i && adr_i == 16'hf748)
    && !$fell(write_pending_flag_o) |-> dat_o[4] == audio_rx_stream_bit_o &&
    dat_o[0] == main_pcm_tx_stream_bit_o && dat_o[9] == gp_input_stream_bit_o
    && dat_o[16] == $past(write_pending_flag_o)) else $error("bad readback");
endmodule
bind sse_slot_gate sse_slot_gate_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o),
  .ack_o(ack_o), .write_pending_flag_o(write_pending_flag_o),
  .audio_rx_stream_bit_o(audio_rx_stream_bit_o),
  .main_pcm_tx_stream_bit_o(main_pcm_tx_stream_bit_o),
  .gp_input_stream_bit_o(gp_input_stream_bit_o));
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, slow, bit_clk;
  logic [15:0] adr_i;
  logic [31:0] dat_i, rd, d, e;
  logic [9:0]  m;
  logic [31:0] q[$];
  wire  [31:0] dat_o;
  wire         ack_o, pend;
  wire  [9:0]  s;
  int          n_fail, n_tests;
  assign s[5] = 1'b0;
  sse_codec_model codec (.slow_i(slow), .bit_clk_o(bit_clk));
  sse_slot_gate dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .bit_clk_i(bit_clk),
    .gp_input_stream_bit_o(s[9]), .gp_output_stream_bit_o(s[8]),
    .modem_rx_stream_bit_o(s[7]), .modem_tx_stream_bit_o(s[6]),
    .audio_rx_stream_bit_o(s[4]), .low_freq_tx_stream_bit_o(s[3]),
    .center_tx_stream_bit_o(s[2]), .rear_pair_tx_stream_bit_o(s[1]),
    .main_pcm_tx_stream_bit_o(s[0]), .write_pending_flag_o(pend));
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task results;
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // classic cycle: hold everything until ack is sampled, then release
  task wb(input logic w, input logic [15:0] a, input logic [31:0] v);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= v;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task chk_rd(input logic [15:0] a, input logic [31:0] x);
    q.push_back(x);
    wb(1'b0, a, 32'h0);
  endtask
  // write, then a write that must be dropped, then poll until applied
  task wr(input logic [15:0] a, input logic [31:0] v);
    wb(1'b1, a, v);
    wb(1'b1, a ^ 16'h0004, ~v);
    chk_rd(16'hf748, {15'h0, 1'b1, 6'h0, m});
    do wb(1'b0, 16'hf748, 32'h0); while (rd[16] !== 1'b0);
    if (a == 16'hf748) m = m | (v[9:0] & 10'h3df);
    else m = m & ~v[9:0];
    chk_rd(16'hf748, {22'h0, m});
  endtask
  // oldest note is judged when read data comes back
  always @(posedge clk_i)
    if (ack_o === 1'b1 && we_i === 1'b0 && q.size() > 0)
    begin
      e = q.pop_front();
      n_tests++;
      if (dat_o !== e || (!e[16] && s !== e[9:0]))
      begin
        n_fail++;
        $display("mismatch %0t read %h pins %h want %h", $time, dat_o, s, e);
      end
    end
  // a stopped link clock would hang the poll; about 2k cycles expected
  initial
  begin
    #400000;
    n_fail++;
    results;
  end
  initial
  begin
    rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0; slow = 1'b0;
    adr_i = 16'h0; dat_i = 32'h0; m = 10'h0; n_fail = 0; n_tests = 0;
    void'($urandom(59));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_rd(16'hf748, 32'h0);
    chk_rd(16'h0010, 32'h0);
    for (int i = 0; i < 10; i++)
      if (i != 5)
      begin
        wr(16'hf748, 32'h1 << i);
        wr(16'hf74c, 32'h1 << i);
      end
    // random full words hit reserved bits and zero writes alike
    for (int i = 0; i < 24; i++)
    begin
      slow <= i[3];
      d = $urandom;
      wr(i[0] ? 16'hf74c : 16'hf748, d);
    end
    // clear every stream first: the monitor also holds the pins to the note
    wr(16'hf74c, 32'h3ff);
    chk_rd(16'hf74c, 32'h0);
    results;
  end
endmodule
`default_nettype wire
